// >>> logic/port_gate_consts.svh
// register map, reset values and field widths of the port gating block
`ifndef PORT_GATE_CONSTS_SVH
`define PORT_GATE_CONSTS_SVH

`define PG_ADDR_W         12
`define PG_DATA_W         32
`define PG_PORT_N         5
`define PG_OFS_DEEP_GATE  12'h128
`define PG_OFS_FAULT_STAT 12'h130
`define PG_OFS_FAULT_MASK 12'h134
`define PG_RST_GATE       5'h00
`define PG_RST_STAT       5'h00
`define PG_RST_MASK       5'h00
`define PG_RST_WORD       32'h0000_0000
`define PG_UPPER_ZERO     27'h000_0000

`endif

// >>> logic/port_gate_pkg.sv
// types shared by the port gating block
package port_gate_pkg;

    // power operating mode seen by the gating selector
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP
    } pwr_mode_e;

    typedef logic [4:0]  port_vec_t;
    typedef logic [31:0] word_t;

    // whole state of the gating block
    typedef struct packed {
        port_vec_t gate;
        port_vec_t clk_en;
        port_vec_t status;
        port_vec_t mask;
        port_vec_t fault;
        word_t     rdata;
    } gate_state_s;

endpackage : port_gate_pkg

// >>> logic/deep_sleep_port_clock_gating.sv
// deep-sleep clock gating control for five general-purpose ports
`timescale 1ns/1ps
`include "port_gate_consts.svh"

module deep_sleep_port_clock_gating (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // register port
    input  wire logic [11:0] reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_write_in,
    input  wire logic        reg_read_in,
    output logic      [31:0] reg_rdata_out,
    // gating context from the system control logic
    input  wire logic [4:0]  run_gate_reg_in,
    input  wire logic [4:0]  sleep_gate_reg_in,
    input  wire logic        auto_gate_select_in,
    input  wire logic        sleep_mode_in,
    input  wire logic        deep_sleep_mode_in,
    // port side
    input  wire logic [4:0]  port_access_in,
    output logic      [4:0]  port_clk_en_out,
    output logic      [4:0]  port_fault_out,
    output logic             bus_fault_out,
    output logic             irq_out
);

    port_gate_pkg::gate_state_s state;
    port_gate_pkg::gate_state_s next_state;
    port_gate_pkg::pwr_mode_e   mode;
    port_gate_pkg::port_vec_t   sel_gate;
    port_gate_pkg::port_vec_t   fault_hit;

    // operating mode; deep sleep outranks ordinary sleep
    always_comb begin
        if (deep_sleep_mode_in) begin
            mode = port_gate_pkg::MODE_DEEP;
        end else if (sleep_mode_in) begin
            mode = port_gate_pkg::MODE_SLEEP;
        end else begin
            mode = port_gate_pkg::MODE_RUN;
        end
    end

    // per-port gate source selection and fault detection
    genvar i;
    generate
        for (i = 0; i < `PG_PORT_N; i++) begin : g_port
            always_comb begin
                if (!auto_gate_select_in) begin
                    sel_gate[i] = run_gate_reg_in[i];
                end else begin
                    unique case (mode)
                        port_gate_pkg::MODE_DEEP:
                            sel_gate[i] = state.gate[i];
                        port_gate_pkg::MODE_SLEEP:
                            sel_gate[i] = sleep_gate_reg_in[i];
                        port_gate_pkg::MODE_RUN:
                            sel_gate[i] = run_gate_reg_in[i];
                        default:
                            sel_gate[i] = 1'b0;
                    endcase
                end
            end
            // access to an unclocked port
            assign fault_hit[i] = port_access_in[i] & ~state.clk_en[i];
        end
    endgenerate

    // next-state logic: registers, enables, faults, read data
    always_comb begin
        logic rd_stat;
        rd_stat = reg_read_in && (reg_addr_in == `PG_OFS_FAULT_STAT);
        next_state = state;
        next_state.clk_en = sel_gate;
        next_state.fault  = fault_hit;
        next_state.rdata  = `PG_RST_WORD;
        // register writes; only the port bits are stored
        if (reg_write_in) begin
            unique case (reg_addr_in)
                `PG_OFS_DEEP_GATE:
                    next_state.gate = reg_wdata_in[4:0];
                `PG_OFS_FAULT_MASK:
                    next_state.mask = reg_wdata_in[4:0];
                default: ;
            endcase
        end
        // register reads, upper bits zero
        if (reg_read_in) begin
            unique case (reg_addr_in)
                `PG_OFS_DEEP_GATE:
                    next_state.rdata = {`PG_UPPER_ZERO, state.gate};
                `PG_OFS_FAULT_STAT:
                    next_state.rdata = {`PG_UPPER_ZERO, state.status};
                `PG_OFS_FAULT_MASK:
                    next_state.rdata = {`PG_UPPER_ZERO, state.mask};
                default:
                    next_state.rdata = `PG_RST_WORD;
            endcase
        end
        // sticky fault status; a new fault wins over read-clear
        if (rd_stat) begin
            next_state.status = fault_hit;
        end else begin
            next_state.status = state.status | fault_hit;
        end
    end

    // state register, synchronous active-low reset
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state.gate   <= `PG_RST_GATE;
            state.clk_en <= `PG_RST_GATE;
            state.status <= `PG_RST_STAT;
            state.mask   <= `PG_RST_MASK;
            state.fault  <= `PG_RST_GATE;
            state.rdata  <= `PG_RST_WORD;
        end else begin
            state <= next_state;
        end
    end

    // outputs
    assign reg_rdata_out   = state.rdata;
    assign port_clk_en_out = state.clk_en;
    assign port_fault_out  = state.fault;
    assign bus_fault_out   = |state.fault;
    assign irq_out         = |(state.status & state.mask);

    // checks
    chk_reset_gates_clear: assert property (
        @(posedge clk_sys_in)
        !rst_n_in |=> (state.gate == `PG_RST_GATE)
                      && (port_clk_en_out == `PG_RST_GATE))
        else $error("gating bits not clear after reset");

    chk_deep_gate_used: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (auto_gate_select_in && deep_sleep_mode_in)
        |=> (port_clk_en_out == $past(state.gate)))
        else $error("deep-sleep enables not applied in deep sleep");

    chk_sleep_gate_used: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (auto_gate_select_in && sleep_mode_in && !deep_sleep_mode_in)
        |=> (port_clk_en_out == $past(sleep_gate_reg_in)))
        else $error("sleep enables not applied in sleep");

    chk_run_gate_used: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (!auto_gate_select_in || (!sleep_mode_in && !deep_sleep_mode_in))
        |=> (port_clk_en_out == $past(run_gate_reg_in)))
        else $error("run enables not applied");

    chk_fault_on_gated: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (|(port_access_in & ~port_clk_en_out))
        |=> bus_fault_out)
        else $error("access to gated port did not fault");

    chk_no_fault_clocked: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (|port_access_in) && ((port_access_in & ~port_clk_en_out) == 5'h00)
        |=> !bus_fault_out)
        else $error("access to clocked port faulted");

    chk_write_readback: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (reg_write_in && reg_addr_in == `PG_OFS_DEEP_GATE)
        ##1 (reg_read_in && reg_addr_in == `PG_OFS_DEEP_GATE
             && !reg_write_in)
        |=> (reg_rdata_out[4:0] == $past(reg_wdata_in[4:0], 2)))
        else $error("gating bits did not read back as written");

    chk_upper_zero: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        $past(reg_read_in) && $past(reg_addr_in) == `PG_OFS_DEEP_GATE
        |-> (reg_rdata_out[31:5] == `PG_UPPER_ZERO))
        else $error("reserved bits did not read zero");

    chk_upper_unstored: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (reg_write_in && reg_addr_in == `PG_OFS_DEEP_GATE)
        |=> (state.gate == $past(reg_wdata_in[4:0])))
        else $error("write did not store only the port bits");

    // access to gated port a faults next cycle
    chk_fault_port_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (port_access_in[0] && !port_clk_en_out[0])
        |=> port_fault_out[0])
        else $error("gated port a access did not fault");

    // access to gated port c faults next cycle
    chk_fault_port_c: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (port_access_in[2] && !port_clk_en_out[2])
        |=> port_fault_out[2])
        else $error("gated port c access did not fault");

    // access to gated port e faults next cycle
    chk_fault_port_e: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (port_access_in[4] && !port_clk_en_out[4])
        |=> port_fault_out[4])
        else $error("gated port e access did not fault");

    // clocked port a never faults
    chk_clocked_port_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (port_access_in[0] && port_clk_en_out[0])
        |=> !port_fault_out[0])
        else $error("clocked port a access faulted");

    // clocked port e never faults
    chk_clocked_port_e: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (port_access_in[4] && port_clk_en_out[4])
        |=> !port_fault_out[4])
        else $error("clocked port e access faulted");

    // no access, no fault
    chk_no_access_quiet: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (port_access_in == 5'h00)
        |=> (port_fault_out == 5'h00))
        else $error("fault without any access");

    // bus fault clears the cycle after accesses stop
    chk_bus_fault_pulse: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (port_access_in == 5'h00)
        |=> !bus_fault_out)
        else $error("bus fault stood without an access");

    // a fault leaves a sticky status bit
    chk_status_set: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (|(port_access_in & ~port_clk_en_out))
        |=> (state.status != `PG_RST_STAT))
        else $error("fault did not set status");

    // status bits only grow until read
    chk_status_sticky: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (!reg_read_in || reg_addr_in != `PG_OFS_FAULT_STAT)
        |=> ((state.status & $past(state.status)) == $past(state.status)))
        else $error("status bit lost without a read");

    // quiet status read clears every bit
    chk_status_clear: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (reg_read_in && reg_addr_in == `PG_OFS_FAULT_STAT && !(|port_access_in))
        |=> (state.status == `PG_RST_STAT))
        else $error("status read did not clear");

    // status read returns the bits held
    chk_status_value: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (reg_read_in && reg_addr_in == `PG_OFS_FAULT_STAT)
        |=> (reg_rdata_out[4:0] == $past(state.status)))
        else $error("status read returned wrong bits");

    // read data stands one cycle, then zero
    chk_rdata_idle: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        !reg_read_in
        |=> (reg_rdata_out == `PG_RST_WORD))
        else $error("read data not zero without a read");

    // mask read returns the bits held
    chk_mask_value: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (reg_read_in && reg_addr_in == `PG_OFS_FAULT_MASK)
        |=> (reg_rdata_out[4:0] == $past(state.mask)))
        else $error("mask read returned wrong bits");

    // mask write stores the port bits
    chk_mask_write: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (reg_write_in && reg_addr_in == `PG_OFS_FAULT_MASK)
        |=> (state.mask == $past(reg_wdata_in[4:0])))
        else $error("mask write not stored");

    // mask holds without a write
    chk_mask_hold: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        !(reg_write_in && reg_addr_in == `PG_OFS_FAULT_MASK)
        |=> $stable(state.mask))
        else $error("mask changed without a write");

    // gating bits hold without a write
    chk_gate_hold: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        !(reg_write_in && reg_addr_in == `PG_OFS_DEEP_GATE)
        |=> $stable(state.gate))
        else $error("gating bits changed without a write");

    // reset clears read data and faults
    chk_reset_outputs: assert property (
        @(posedge clk_sys_in)
        !rst_n_in
        |=> (reg_rdata_out == `PG_RST_WORD) && !bus_fault_out)
        else $error("outputs not clear after reset");

    // reset clears status and interrupt
    chk_reset_irq: assert property (
        @(posedge clk_sys_in)
        !rst_n_in
        |=> !irq_out && (state.status == `PG_RST_STAT))
        else $error("interrupt not clear after reset");

    // manual select keeps the run set
    chk_manual_run: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        !auto_gate_select_in
        |=> (port_clk_en_out == $past(run_gate_reg_in)))
        else $error("run set not used without auto select");

    // deep sleep with bit a clear stops port a
    chk_deep_port_a_off: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (auto_gate_select_in && deep_sleep_mode_in && !state.gate[0])
        |=> !port_clk_en_out[0])
        else $error("port a clocked in deep sleep");

    // deep sleep with bit e set clocks port e
    chk_deep_port_e_on: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (auto_gate_select_in && deep_sleep_mode_in && state.gate[4])
        |=> port_clk_en_out[4])
        else $error("port e not clocked in deep sleep");

endmodule : deep_sleep_port_clock_gating

// >>> tb/tb_top.sv
// self-checking bench for the deep-sleep port clock gating block
`timescale 1ns/1ps
`include "port_gate_consts.svh"

module tb_top;
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [11:0] reg_addr_in = 12'h000;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic        reg_write_in = 1'b0;
    logic        reg_read_in = 1'b0;
    logic [4:0]  run_gate_reg_in = 5'h00;
    logic [4:0]  sleep_gate_reg_in = 5'h00;
    logic        auto_gate_select_in = 1'b0;
    logic        sleep_mode_in = 1'b0;
    logic        deep_sleep_mode_in = 1'b0;
    logic [4:0]  port_access_in = 5'h00;
    logic [31:0] reg_rdata_out;
    logic        bus_fault_out, irq_out;
    logic [4:0]  port_clk_en_out, port_fault_out, st, msk, g, e, f, a;
    integer      seed, failures = 0, n_tests = 0;

    deep_sleep_port_clock_gating deep_sleep_port_clock_gating_inst (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out), .run_gate_reg_in(run_gate_reg_in),
        .sleep_gate_reg_in(sleep_gate_reg_in),
        .auto_gate_select_in(auto_gate_select_in),
        .sleep_mode_in(sleep_mode_in),
        .deep_sleep_mode_in(deep_sleep_mode_in),
        .port_access_in(port_access_in), .port_clk_en_out(port_clk_en_out),
        .port_fault_out(port_fault_out), .bus_fault_out(bus_fault_out),
        .irq_out(irq_out)
    );

    // 100 mhz system clock
    always #5 clk_sys_in = ~clk_sys_in;

    task automatic chk_w(input port_gate_pkg::word_t got, exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t word got %h want %h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_v(input port_gate_pkg::port_vec_t got, exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t bits got %h want %h", $time, got, exp);
        end
    endtask : chk_v

    // one-cycle write strobe, entered right after a rising edge
    task automatic wr(input logic [11:0] ad, input port_gate_pkg::word_t d);
        reg_addr_in <= ad;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_write_in <= 1'b0;
    endtask : wr

    // read strobe, data checked in the following cycle
    task automatic rd(input logic [11:0] ad, input port_gate_pkg::word_t x);
        reg_addr_in <= ad;
        reg_read_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_read_in <= 1'b0;
        @(negedge clk_sys_in);
        chk_w(reg_rdata_out, x);
        @(posedge clk_sys_in);
    endtask : rd

    // enable source chosen by mode and auto select
    function automatic port_gate_pkg::port_vec_t exp_en(input logic [4:0] gv);
        if (auto_gate_select_in && deep_sleep_mode_in)
            return gv;
        if (auto_gate_select_in && sleep_mode_in)
            return sleep_gate_reg_in;
        return run_gate_reg_in;
    endfunction : exp_en

    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // hang guard
    initial begin
        repeat (3000) @(posedge clk_sys_in);
        failures++;
        close_out();
    end

    // main sequence
    initial begin
        seed = 32'h8b2f;
        st = 5'h00;
        repeat (4) @(negedge clk_sys_in);
        chk_v(port_clk_en_out, 5'h00);
        @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        rd(`PG_OFS_DEEP_GATE, 32'h0000_0000);
        rd(12'h12c, 32'h0000_0000);
        msk = 5'($random(seed));
        wr(`PG_OFS_FAULT_MASK, {27'($random(seed)), msk});
        rd(`PG_OFS_FAULT_MASK, {27'h000_0000, msk});
        wr(`PG_OFS_DEEP_GATE, 32'hffff_ffff);
        rd(`PG_OFS_DEEP_GATE, 32'h0000_001f);
        for (int i = 0; i < 24; i++) begin
            g = 5'($random(seed));
            wr(`PG_OFS_DEEP_GATE, {27'($random(seed)), g});
            rd(`PG_OFS_DEEP_GATE, {27'h000_0000, g});
            run_gate_reg_in <= 5'($random(seed));
            sleep_gate_reg_in <= 5'($random(seed));
            {auto_gate_select_in, sleep_mode_in, deep_sleep_mode_in} <= 3'(i);
            repeat (2) @(posedge clk_sys_in);
            @(negedge clk_sys_in);
            e = exp_en(g);
            chk_v(port_clk_en_out, e);
            @(posedge clk_sys_in);
            a = 5'($random(seed));
            port_access_in <= a;
            @(posedge clk_sys_in);
            port_access_in <= 5'h00;
            f = a & ~e;
            st = st | f;
            @(negedge clk_sys_in);
            chk_v(port_fault_out, f);
            chk_v({4'h0, bus_fault_out}, {4'h0, |f});
            chk_v({4'h0, irq_out}, {4'h0, |(st & msk)});
            @(posedge clk_sys_in);
            if (i % 3 == 2) begin
                rd(`PG_OFS_FAULT_STAT, {27'h000_0000, st});
                st = 5'h00;
            end
        end
        close_out();
    end
endmodule : tb_top
